// File: verilog/agc_pkg.sv
package agc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  // Register indices 4h, 5h, 6h: byte address = 4 * index
  localparam logic [7:0] IDX_GAIN = 8'h04;
  localparam logic [7:0] IDX_RSVD = 8'h05;
  localparam logic [7:0] IDX_MISC = 8'h06;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;

  // Reset values
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [15:0] RST_RSVD = 16'h0000;
  localparam logic [15:0] RST_MISC = 16'h0600;

  // ************************************************************
  // Gain field layout
  // ************************************************************
  localparam int GAIN_CH0_LSB = 0;
  localparam int GAIN_CH1_LSB = 4;
  localparam int GAIN_CH2_LSB = 8;
  localparam int GAIN_FLD_W = 3;
  localparam int NUM_CH = 3;
  localparam logic [2:0] GAIN_UNITY = 3'h0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write request carried from the bus slave to the register file
  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [15:0] data;
    logic [1:0] strb;
  } agc_wreq_t;

  // One-hot slave channel states
  typedef enum logic [1:0] {
    AGC_IDLE = 2'b01,
    AGC_RESP = 2'b10
  } agc_state_t;

endpackage : agc_pkg

// File: verilog/agc_axil_slave.sv
// ************************************************************
// AXI4-Lite slave front end
// ************************************************************
//
// The AXI4-Lite register port was chosen for this implementation.
module agc_axil_slave
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output agc_pkg::agc_wreq_t wreq,
  output logic [7:0] rd_idx,
  input wire logic [15:0] rd_data,
  input wire logic rd_hit
);

  // Index decode for a word address
  function automatic logic [7:0] to_idx(input logic [7:0] a);
    to_idx = {2'h0, a[7:2]};
  endfunction : to_idx

  function automatic logic mapped(input logic [7:0] a);
    mapped = (to_idx(a) == agc_pkg::IDX_GAIN) || (to_idx(a) == agc_pkg::IDX_RSVD) ||
      (to_idx(a) == agc_pkg::IDX_MISC);
  endfunction : mapped

  agc_pkg::agc_state_t wstate;
  agc_pkg::agc_state_t rstate;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic aw_now;
  logic w_now;
  logic [7:0] next_awa;
  logic [31:0] next_wd;
  logic [3:0] next_ws;
  logic do_write;

  // Address and data accepted independently
  assign awready = (wstate == agc_pkg::AGC_IDLE) && !aw_held;
  assign wready = (wstate == agc_pkg::AGC_IDLE) && !w_held;
  assign aw_now = awvalid && awready;
  assign w_now = wvalid && wready;
  assign next_awa = aw_held ? aw_q : awaddr;
  assign next_wd = w_held ? w_q : wdata;
  assign next_ws = w_held ? s_q : wstrb;
  assign do_write = (wstate == agc_pkg::AGC_IDLE) && (aw_held || aw_now) && (w_held || w_now);
  assign wreq = '{en: do_write && mapped(next_awa), idx: to_idx(next_awa),
    data: next_wd[15:0], strb: next_ws[1:0]};

  // Holding of early write halves
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      if (aw_now)
      begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (w_now)
      begin
        w_held <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
    end
  end

  // Write response channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate <= agc_pkg::AGC_IDLE;
      bvalid <= 1'b0;
      bresp <= agc_pkg::RESP_OKAY;
    end
    else
    begin
      unique case (wstate)
        agc_pkg::AGC_IDLE:
          if (do_write)
          begin
            wstate <= agc_pkg::AGC_RESP;
            bvalid <= 1'b1;
            bresp <= mapped(next_awa) ? agc_pkg::RESP_OKAY : agc_pkg::RESP_SLVERR;
          end
        agc_pkg::AGC_RESP:
          if (bready)
          begin
            wstate <= agc_pkg::AGC_IDLE;
            bvalid <= 1'b0;
          end
        default:
          wstate <= agc_pkg::AGC_IDLE;
      endcase
    end
  end

  // Read channel, data registered
  assign arready = (rstate == agc_pkg::AGC_IDLE);
  assign rd_idx = to_idx(araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rstate <= agc_pkg::AGC_IDLE;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= agc_pkg::RESP_OKAY;
    end
    else
    begin
      unique case (rstate)
        agc_pkg::AGC_IDLE:
          if (arvalid)
          begin
            rstate <= agc_pkg::AGC_RESP;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_data};
            rresp <= rd_hit ? agc_pkg::RESP_OKAY : agc_pkg::RESP_SLVERR;
          end
        agc_pkg::AGC_RESP:
          if (rready)
          begin
            rstate <= agc_pkg::AGC_IDLE;
            rvalid <= 1'b0;
          end
        default:
          rstate <= agc_pkg::AGC_IDLE;
      endcase
    end
  end

endmodule : agc_axil_slave

// File: verilog/agc_gain_decode.sv
// ************************************************************
// Gain code to multiplier decode, one per channel
// ************************************************************
module agc_gain_decode
#(
  parameter int NUM_CH = 3
)
(
  input wire logic [3*NUM_CH-1:0] codes,
  output logic [8*NUM_CH-1:0] factors
);

  // Elaboration-time channel count check
  if (NUM_CH < 1)
  begin : g_bad_ch
    $error("agc_gain_decode needs at least one channel");
  end

  // Code n selects gain 2**n, 1 up to 128
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    assign factors[8*c +: 8] = 8'h01 << codes[3*c +: 3];
  end

endmodule : agc_gain_decode

// File: verilog/agc_regs.sv
// ************************************************************
// Gain configuration register bank
// ************************************************************
module agc_regs
#(
  parameter int NUM_CH = agc_pkg::NUM_CH
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] amp_gain_ch0,
  output logic [2:0] amp_gain_ch1,
  output logic [2:0] amp_gain_ch2,
  output logic [23:0] amp_gain_factor,
  output logic [15:0] misc_config
);

  // Elaboration-time channel count check
  if (NUM_CH != 3)
  begin : g_bad_ch
    $error("agc_regs serves exactly three channels");
  end

  // ************************************************************
  // Storage
  // ************************************************************
  agc_pkg::agc_wreq_t wreq;
  logic [7:0] rd_idx;
  logic [15:0] rd_data;
  logic rd_hit;
  logic [15:0] channel_gain_select;
  logic [15:0] reserved_slot;
  logic [15:0] next_gain;
  logic [15:0] next_rsvd;
  logic [15:0] next_misc;

  // Byte-lane merge of new data over old
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
    input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  agc_axil_slave agc_axil_slave_inst
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wreq(wreq),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  assign next_gain = merge(channel_gain_select, wreq.data, wreq.strb);
  assign next_rsvd = merge(reserved_slot, wreq.data, wreq.strb);
  assign next_misc = merge(misc_config, wreq.data, wreq.strb);

  // Gain select register, strobed bytes of the word stored as written
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      channel_gain_select <= agc_pkg::RST_GAIN;
    else if (wreq.en && (wreq.idx == agc_pkg::IDX_GAIN))
      channel_gain_select <= next_gain;
  end

  // Reserved slot, stored and read back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reserved_slot <= agc_pkg::RST_RSVD;
    else if (wreq.en && (wreq.idx == agc_pkg::IDX_RSVD))
      reserved_slot <= next_rsvd;
  end

  // Following configuration register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      misc_config <= agc_pkg::RST_MISC;
    else if (wreq.en && (wreq.idx == agc_pkg::IDX_MISC))
      misc_config <= next_misc;
  end

  // ************************************************************
  // Gain fields to the amplifiers
  // ************************************************************
  assign amp_gain_ch2 = channel_gain_select[agc_pkg::GAIN_CH2_LSB +: 3];
  assign amp_gain_ch1 = channel_gain_select[agc_pkg::GAIN_CH1_LSB +: 3];
  assign amp_gain_ch0 = channel_gain_select[agc_pkg::GAIN_CH0_LSB +: 3];

  // Multipliers 1..128 per channel, channel 0 lowest byte
  agc_gain_decode #(.NUM_CH(NUM_CH)) agc_gain_decode_inst
  (
    .codes({amp_gain_ch2, amp_gain_ch1, amp_gain_ch0}),
    .factors(amp_gain_factor)
  );

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      agc_pkg::IDX_GAIN: rd_data = channel_gain_select;
      agc_pkg::IDX_RSVD: rd_data = reserved_slot;
      agc_pkg::IDX_MISC: rd_data = misc_config;
      default:
      begin
        rd_data = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

endmodule : agc_regs

// File: testbench/agc_regs_properties.sv
// ************************************************************
// Port checker for the gain register bank
// ************************************************************
module agc_regs_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [2:0] amp_gain_ch0,
  input wire logic [2:0] amp_gain_ch1,
  input wire logic [2:0] amp_gain_ch2,
  input wire logic [23:0] amp_gain_factor,
  input wire logic [15:0] misc_config
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [31:0] wdata_q;

  // Write data of the previous cycle
  always_ff @(posedge aclk)
    wdata_q <= s_axi_wdata;

  // Address and data taken on one edge
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // Full-word write to one register
  sequence s_full_wr(logic [7:0] a);
    s_both_taken ##0 (s_axi_awaddr == a) && (s_axi_wstrb == 4'hF);
  endsequence

  property p_reset_value;
    disable iff (1'b0)
    $rose(aresetn) |-> misc_config == 16'h0600 && amp_gain_ch0 == 3'h0 &&
      amp_gain_ch1 == 3'h0 && amp_gain_ch2 == 3'h0;
  endproperty

  a_reset_value: assert property (p_reset_value)
    else $error("register outputs not at reset values");
  a_wr_answer: assert property (s_both_taken |=> s_axi_bvalid)
    else $error("no write response one cycle after the write");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data one cycle after the read address");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data above the 16-bit register not zero");
  a_gain_write: assert property (s_full_wr(8'h10) |=>
    {amp_gain_ch2, amp_gain_ch1, amp_gain_ch0} == {wdata_q[10:8], wdata_q[6:4], wdata_q[2:0]})
    else $error("gain fields do not follow the written word");
  a_misc_write: assert property (
    s_full_wr(8'h18) |=> misc_config == wdata_q[15:0])
    else $error("misc register does not follow the written word");
  a_factor_map: assert property (amp_gain_factor ==
    {8'h01 << amp_gain_ch2, 8'h01 << amp_gain_ch1, 8'h01 << amp_gain_ch0})
    else $error("gain factor not a power of two of the code");
endmodule : agc_regs_properties

bind agc_regs agc_regs_properties agc_regs_properties_inst
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .amp_gain_ch0, .amp_gain_ch1,
  .amp_gain_ch2, .amp_gain_factor, .misc_config
);

// File: testbench/adc_gain_config_regs_tb.sv
module adc_gain_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [2:0] amp_gain_ch0;
  logic [2:0] amp_gain_ch1;
  logic [2:0] amp_gain_ch2;
  logic [23:0] amp_gain_factor;
  logic [15:0] misc_config;
  logic [15:0] g;
  int fail_count = 0;
  int n_tests = 0;

  agc_regs agc_regs_inst
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .amp_gain_ch0, .amp_gain_ch1, .amp_gain_ch2, .amp_gain_factor, .misc_config
  );

  // 20 MHz clock
  always #25 aclk = ~aclk;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Write with response stalled dly cycles
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input int dly, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    repeat (dly) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    s_axi_bready <= 1'b0;
  endtask : axi_write

  // Read and compare data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input int dly);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (dly) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    check(s_axi_rdata, ed, "read data");
    check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    s_axi_rready <= 1'b0;
  endtask : rd_chk

  // Gain, factor and misc outputs against expected register contents
  task automatic port_chk(input logic [15:0] eg, input logic [15:0] em);
    check({23'h0, amp_gain_ch2, amp_gain_ch1, amp_gain_ch0},
          {23'h0, eg[10:8], eg[6:4], eg[2:0]}, "gain ports");
    check({8'h00, amp_gain_factor},
          {8'h00, 8'h01 << eg[10:8], 8'h01 << eg[6:4], 8'h01 << eg[2:0]}, "gain factor");
    check({16'h0000, misc_config}, {16'h0000, em}, "misc port");
  endtask : port_chk

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    do_reset();
    rd_chk(8'h10, 32'h0000_0000, 2'h0, 0);
    rd_chk(8'h14, 32'h0000_0000, 2'h0, 1);
    rd_chk(8'h18, 32'h0000_0600, 2'h0, 0);
    port_chk(16'h0000, 16'h0600);
    $display("test reset_values done");
    for (int c = 0; c < 8; c++)
    begin
      g = {5'h00, 3'(c ^ 5), 1'b0, 3'(7 - c), 1'b0, 3'(c)};
      axi_write(8'h10, {16'h0000, g}, 4'hF, c % 3, 2'h0);
      port_chk(g, 16'h0600);
      rd_chk(8'h10, {16'h0000, g}, 2'h0, c % 2);
    end
    $display("test gain_codes done");
    axi_write(8'h14, 32'h0000_0000, 4'hF, 3, 2'h0);
    rd_chk(8'h14, 32'h0000_0000, 2'h0, 2);
    axi_write(8'h18, 32'hFFFF_A5C3, 4'hF, 0, 2'h0);
    rd_chk(8'h18, 32'h0000_A5C3, 2'h0, 0);
    port_chk(g, 16'hA5C3);
    $display("test reserved_misc done");
    axi_write(8'h10, 32'h0000_0500, 4'h2, 1, 2'h0);
    g[15:8] = 8'h05;
    port_chk(g, 16'hA5C3);
    axi_write(8'h40, 32'hFFFF_FFFF, 4'hF, 0, 2'h2);
    rd_chk(8'h40, 32'h0000_0000, 2'h2, 0);
    port_chk(g, 16'hA5C3);
    $display("test strobe_unmapped done");
    do_reset();
    port_chk(16'h0000, 16'h0600);
    rd_chk(8'h18, 32'h0000_0600, 2'h0, 0);
    $display("test second_reset done");
    end_of_test();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    $display("CHECK FAILED at %0t ns: watchdog expired", $time);
    end_of_test();
  end
endmodule : adc_gain_config_regs_tb
